// File: include/pcf_pkg.sv
// Shared constants and types for the PWM channel output stage
`default_nettype none
package pcf_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam int PCF_CNT_W = 16;
    localparam logic [3:0] PCF_OFS_CTRL = 4'h0;
    localparam logic [3:0] PCF_OFS_PERIOD = 4'h4;
    localparam logic [3:0] PCF_OFS_DUTY = 4'h8;
    localparam logic [3:0] PCF_OFS_STATUS = 4'hC;

    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int PCF_CTRL_W = 13;
    localparam int PCF_B_EN = 0;
    localparam int PCF_B_FREEZE = 1;
    localparam int PCF_B_SL = 2;
    localparam int PCF_B_UD = 3;
    localparam int PCF_B_MODE = 5;
    localparam int PCF_B_RSTTRIG = 7;
    localparam int PCF_B_TRIGSEL = 8;
    localparam int PCF_B_FUPD = 9;
    localparam int PCF_B_RSTCN = 11;
    localparam int PCF_B_FORCE = 16;
    localparam int PCF_B_ST_MAIN = 16;
    localparam int PCF_B_ST_COMP = 17;
    localparam int PCF_B_ST_DOWN = 18;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [1:0] PCF_MODE_PWM = 2'h2;
    localparam logic [1:0] PCF_FUPD_ON = 2'h2;
    localparam logic [1:0] PCF_RSTCN_ON = 2'h2;
    localparam logic [1:0] PCF_UD_UP = 2'h0;
    localparam logic [PCF_CTRL_W-1:0] PCF_CTRL_RST = 13'h0000;
    localparam logic [PCF_CNT_W-1:0] PCF_CMP_RST = 16'h0000;
    localparam logic [31:0] PCF_RD_NONE = 32'h00000000;

    typedef enum logic [1:0] {
        PCF_DIR_UP = 2'b01,
        PCF_DIR_DOWN = 2'b10
    } pcf_dir_type;
endpackage
`default_nettype wire

// File: hw/pcf_counter.sv
// Period counter with continuous up and up-down counting
`default_nettype none
module pcf_counter
    import pcf_pkg::*;
#(
    parameter int CNT_W = PCF_CNT_W
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic up_down,
    input wire logic clear,
    input wire logic dir_reset,
    input wire logic [CNT_W-1:0] period,
    output logic [CNT_W-1:0] count,
    output pcf_dir_type dir
);
    wire [CNT_W-1:0] count_inc = count + 1'b1;
    wire [CNT_W-1:0] count_dec = count - 1'b1;
    wire wrap_up = (count_inc >= period) | (count_inc == '0);
    wire turn_down = count_inc >= period;
    wire turn_up = count <= 1;
    logic [CNT_W-1:0] next_count;
    pcf_dir_type next_dir;

    always_comb begin
        next_count = count;
        next_dir = dir;
        if (clear) begin
            next_count = '0;
            next_dir = PCF_DIR_UP;
        end else if (!up_down) begin
            // Stale down direction from an earlier mode is dropped here
            next_dir = PCF_DIR_UP;
            if (run) begin
                next_count = wrap_up ? '0 : count_inc;
            end
        end else if (run) begin
            case (dir)
                PCF_DIR_UP: begin
                    next_count = (period == '0) ? '0 : count_inc;
                    if (turn_down) begin
                        next_dir = PCF_DIR_DOWN;
                    end
                end
                PCF_DIR_DOWN: begin
                    next_count = (count == '0) ? '0 : count_dec;
                    if (turn_up) begin
                        next_dir = PCF_DIR_UP;
                    end
                end
                default: begin
                    next_dir = PCF_DIR_UP;
                end
            endcase
            if (dir_reset) begin
                next_dir = PCF_DIR_UP;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
            dir <= PCF_DIR_UP;
        end else begin
            count <= next_count;
            dir <= next_dir;
        end
    end
endmodule
`default_nettype wire

// File: hw/pcf_wave.sv
// Output stage: main and complementary waveform with freeze hold
`default_nettype none
module pcf_wave
    import pcf_pkg::*;
#(
    parameter int CNT_W = PCF_CNT_W
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic hold,
    input wire logic up_down,
    input wire logic start_period,
    input wire logic level,
    input wire logic [CNT_W-1:0] count,
    input wire logic [CNT_W-1:0] duty,
    output logic main_out,
    output logic comp_out
);
    wire up_next = (count == duty) ? ~level : ((count == '0) ? level : main_out);
    wire ud_next = (count < duty) ? level : ~level;
    wire run_next = start_period ? level : (up_down ? ud_next : up_next);
    logic next_main;
    logic next_comp;

    always_comb begin
        next_main = main_out;
        next_comp = comp_out;
        if (hold) begin
            next_main = main_out;
            next_comp = comp_out;
        end else if (!run) begin
            next_main = ~level;
            next_comp = level;
        end else begin
            next_main = run_next;
            next_comp = ~run_next;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            main_out <= 1'b0;
            comp_out <= 1'b1;
        end else begin
            main_out <= next_main;
            comp_out <= next_comp;
        end
    end
endmodule
`default_nettype wire

// File: hw/pcf_channel.sv
// PWM channel: Avalon-MM registers, period counter and output stage
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`default_nettype none

// Notes on behaviour
// - Frozen and disabled channel keeps both outputs at their last levels.
// - Freeze means freeze bit 1 and enable 0; also with up-down trigger reset.
// - Up-down trigger comes from preceding channel or input unit capture.
// - Mode field 0 counts up, above 0 up-down; PWM when mode is 10.
// - Forced update with both controls at 10 clears the period counter.
// - Forced counter clear on a running channel drives main output to the signal level at once.
// - Counter reaching duty compare drives main output to inverse level.
// - Level changed together with forced update still gets the duty edge.
// - Output level comes from the signal level bit, changeable while running.
module pcf_channel
    import pcf_pkg::*;
#(
    parameter int CNT_W = PCF_CNT_W
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic preceding_channel_trigger,
    input wire logic input_unit_capture_trigger,
    output logic main_waveform_output,
    output logic complementary_waveform_output
);
    // ************************************************************
    // Byte lane merge
    // ************************************************************
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0] be
    );
        logic [31:0] result;
        result = old_value;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                result[8*i +: 8] = new_value[8*i +: 8];
            end
        end
        return result;
    endfunction

    // ************************************************************
    // Register state
    // ************************************************************
    logic [PCF_CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] period_compare_value;
    logic [CNT_W-1:0] duty_compare_value;
    logic force_req;
    logic [CNT_W-1:0] period_counter;
    pcf_dir_type count_dir;

    // ************************************************************
    // Bus decode
    // ************************************************************
    // One wait state: the first request cycle is always stalled, so that
    // read data and waitrequest can both come from flip-flops.
    wire bus_req = avs_read | avs_write;
    wire bus_accept = bus_req & ~avs_waitrequest;
    wire wr_go = avs_write & bus_accept;
    wire sel_ctrl = avs_address == PCF_OFS_CTRL;
    wire sel_period = avs_address == PCF_OFS_PERIOD;
    wire sel_duty = avs_address == PCF_OFS_DUTY;
    wire sel_status = avs_address == PCF_OFS_STATUS;
    wire [31:0] ctrl_wide = 32'(ctrl);
    wire [31:0] ctrl_merged = be_merge(ctrl_wide, avs_writedata, avs_byteenable);
    wire [31:0] period_merged = be_merge(32'(period_compare_value), avs_writedata,
        avs_byteenable);
    wire [31:0] duty_merged = be_merge(32'(duty_compare_value), avs_writedata,
        avs_byteenable);
    wire force_bit = avs_writedata[PCF_B_FORCE] & avs_byteenable[2];
    wire force_armed = (ctrl_merged[PCF_B_FUPD +: 2] == PCF_FUPD_ON)
        & (ctrl_merged[PCF_B_RSTCN +: 2] == PCF_RSTCN_ON);
    wire next_force = wr_go & sel_ctrl & force_bit & force_armed;

    // ************************************************************
    // Control fields
    // ************************************************************
    wire channel_enable_status = ctrl[PCF_B_EN];
    wire freeze = ctrl[PCF_B_FREEZE];
    wire signal_level_select = ctrl[PCF_B_SL];
    wire [1:0] count_direction_mode = ctrl[PCF_B_UD +: 2];
    wire [1:0] pulse_width_output_mode = ctrl[PCF_B_MODE +: 2];
    wire counter_reset_by_trigger = ctrl[PCF_B_RSTTRIG];
    wire trigger_from_capture = ctrl[PCF_B_TRIGSEL];
    wire up_down = count_direction_mode != PCF_UD_UP;
    wire run = channel_enable_status & (pulse_width_output_mode == PCF_MODE_PWM);
    wire hold = freeze & ~channel_enable_status;
    // A trigger from the selected source only resets the direction, never the count
    wire sel_trigger = trigger_from_capture ? input_unit_capture_trigger
        : preceding_channel_trigger;
    wire dir_reset = counter_reset_by_trigger & up_down & sel_trigger;

    // ************************************************************
    // Read data
    // ************************************************************
    wire [31:0] status_word = 32'(period_counter)
        | (32'(main_waveform_output) << PCF_B_ST_MAIN)
        | (32'(complementary_waveform_output) << PCF_B_ST_COMP)
        | (32'(count_dir == PCF_DIR_DOWN) << PCF_B_ST_DOWN);
    wire [31:0] rd_value = sel_ctrl ? ctrl_wide
        : sel_period ? 32'(period_compare_value)
        : sel_duty ? 32'(duty_compare_value)
        : sel_status ? status_word
        : PCF_RD_NONE;

    // ************************************************************
    // Bus and register flops
    // ************************************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= PCF_RD_NONE;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= rd_value;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= PCF_CTRL_RST;
            period_compare_value <= PCF_CMP_RST;
            duty_compare_value <= PCF_CMP_RST;
            force_req <= 1'b0;
        end else begin
            force_req <= next_force;
            if (wr_go & sel_ctrl) begin
                ctrl <= ctrl_merged[PCF_CTRL_W-1:0];
            end
            if (wr_go & sel_period) begin
                period_compare_value <= period_merged[CNT_W-1:0];
            end
            if (wr_go & sel_duty) begin
                duty_compare_value <= duty_merged[CNT_W-1:0];
            end
        end
    end

    // ************************************************************
    // Counter and output stage
    // ************************************************************
    pcf_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(run),
        .up_down(up_down),
        .clear(force_req),
        .dir_reset(dir_reset),
        .period(period_compare_value),
        .count(period_counter),
        .dir(count_dir)
    );

    // The force pulse is registered on the same edge as the control write, so the level
    // written together with it is already in place for both edges.
    pcf_wave #(
        .CNT_W(CNT_W)
    ) u_wave (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(run),
        .hold(hold),
        .up_down(up_down),
        .start_period(force_req),
        .level(signal_level_select),
        .count(period_counter),
        .duty(duty_compare_value),
        .main_out(main_waveform_output),
        .comp_out(complementary_waveform_output)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    a_freeze_hold_main: assert property (@(posedge core_clk) disable iff (!resetn)
        hold |=> main_waveform_output == $past(main_waveform_output))
        else $error("main output moved while frozen");

    a_freeze_hold_comp: assert property (@(posedge core_clk) disable iff (!resetn)
        (hold && up_down && counter_reset_by_trigger)
        |=> $stable(complementary_waveform_output))
        else $error("complementary output moved while frozen");

    a_trigger_dir_reset: assert property (@(posedge core_clk) disable iff (!resetn)
        (run && dir_reset && !force_req) |=> count_dir == PCF_DIR_UP)
        else $error("trigger did not reset count direction");

    a_up_mode_dir: assert property (@(posedge core_clk) disable iff (!resetn)
        (run && !up_down && !force_req && period_compare_value > 1
            && period_counter == period_compare_value - 1)
        |=> period_counter == 0 && count_dir == PCF_DIR_UP)
        else $error("up counter did not wrap at period");

    a_idle_level: assert property (@(posedge core_clk) disable iff (!resetn)
        (!run && !hold) |=> main_waveform_output == ~$past(signal_level_select))
        else $error("non-PWM channel not idle");

    a_force_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(force_req) |-> $past(wr_go) ##1 period_counter == 0)
        else $error("forced update did not clear counter");

    a_force_level: assert property (@(posedge core_clk) disable iff (!resetn)
        (force_req && run && !hold) |=> main_waveform_output == $past(signal_level_select))
        else $error("forced period start missed the level edge");

    a_duty_edge: assert property (@(posedge core_clk) disable iff (!resetn)
        (run && !hold && !up_down && !force_req && period_counter == duty_compare_value)
        |=> main_waveform_output == ~$past(signal_level_select))
        else $error("missing duty edge");

    a_new_level_edge: assert property (@(posedge core_clk) disable iff (!resetn)
        (force_req && run && !hold && !up_down && duty_compare_value == 1
            && period_compare_value > 2
            && signal_level_select != $past(signal_level_select))
        |=> ##2 main_waveform_output == ~$past(signal_level_select, 2))
        else $error("duty edge lost after level change with forced update");

    a_ud_level: assert property (@(posedge core_clk) disable iff (!resetn)
        (run && !hold && up_down && !force_req && period_counter >= duty_compare_value)
        |=> main_waveform_output == ~$past(signal_level_select))
        else $error("up-down output ignores signal level");

    a_comp_inverse: assert property (@(posedge core_clk) disable iff (!resetn)
        (run && !hold) |=> complementary_waveform_output == ~main_waveform_output)
        else $error("complementary output not inverse of main");
endmodule
`default_nettype wire

// File: tb/pcf_load_model.sv
// Load on the channel's pins: counts main rising edges and complement clashes
`default_nettype none
module pcf_load_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic main_in,
    input wire logic comp_in,
    output logic [15:0] rise_count,
    output logic [15:0] clash_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_main;
    // A held output never rises, so a frozen channel shows a still count
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            last_main <= 1'b0;
            rise_count <= 16'h0000;
            clash_count <= 16'h0000;
        end else begin
            last_main <= main_in;
            if (main_in && !last_main) begin
                rise_count <= rise_count + 16'h0001;
            end
            // The pins stay complementary in every state
            if (main_in === comp_in) begin
                clash_count <= clash_count + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/pwm_channel_freeze_force_update_test.sv
// Self-checking bench for the PWM channel output stage
`default_nettype none
module pwm_channel_freeze_force_update_test;
    import pcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [31:0] e; logic [31:0] m;} pcf_note_type;
    localparam logic HI = 1'h1;
    localparam logic LO = 1'h0;
    logic core_clk = 1'b0;
    logic resetn;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pre_trig;
    logic cap_trig;
    logic main_waveform_output;
    logic complementary_waveform_output;
    logic [15:0] rises;
    logic [15:0] clashes;
    logic [1:0] fu_tab [4] = '{2'h2, 2'h1, 2'h2, 2'h3};
    logic [1:0] rc_tab [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    pcf_note_type notes[$];
    logic [31:0] seed = 32'hB8739C82;

    always #2 core_clk = ~core_clk;

    pcf_channel #(.CNT_W(PCF_CNT_W)) dut (.core_clk(core_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .preceding_channel_trigger(pre_trig), .input_unit_capture_trigger(cap_trig),
        .main_waveform_output(main_waveform_output),
        .complementary_waveform_output(complementary_waveform_output));
    pcf_load_model load (.core_clk(core_clk), .resetn(resetn),
        .main_in(main_waveform_output), .comp_in(complementary_waveform_output),
        .rise_count(rises), .clash_count(clashes));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task ok(input logic b);
        check({31'h0, b}, 32'h1);
    endtask

    task pin(input logic m, input logic c);
        check({30'h0, main_waveform_output, complementary_waveform_output}, {30'h0, m, c});
    endtask

    task close_out;
        $display("Comparisons %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
        output logic [31:0] q);
        notes.push_back('{e, m});
        bus(1'b0, a, 32'h0, 4'hF, q);
    endtask

    task cw(input logic en, fz, sl, input logic [1:0] ud, input logic rt, ts,
        input logic [1:0] fu, rc, input logic frc);
        wr(PCF_OFS_CTRL, (32'(en) << PCF_B_EN) | (32'(fz) << PCF_B_FREEZE)
            | (32'(sl) << PCF_B_SL) | (32'(ud) << PCF_B_UD) | (32'(PCF_MODE_PWM) << PCF_B_MODE)
            | (32'(rt) << PCF_B_RSTTRIG) | (32'(ts) << PCF_B_TRIGSEL) | (32'(fu) << PCF_B_FUPD)
            | (32'(rc) << PCF_B_RSTCN) | (32'(frc) << PCF_B_FORCE));
    endtask

    task pulse(input logic cap);
        @(posedge core_clk);
        cap_trig <= cap;
        pre_trig <= ~cap;
        @(posedge core_clk);
        cap_trig <= 1'b0;
        pre_trig <= 1'b0;
    endtask

    // Read results are matched against the oldest note; a zero mask is a poll
    always @(posedge core_clk) begin
        pcf_note_type n;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0) begin
            n = notes.pop_front();
            if (n.m != 32'h0) check(avs_readdata & n.m, n.e);
        end
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        logic [31:0] q;
        logic m;
        logic c;
        logic [15:0] r;
        int k;
        int h;
        resetn = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        pre_trig = 1'b0;
        cap_trig = 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        rd(PCF_OFS_CTRL, 32'(PCF_CTRL_RST), 32'hFFFFFFFF, q);
        rd(PCF_OFS_DUTY, 32'(PCF_CMP_RST), 32'hFFFFFFFF, q);
        rd(4'h2, PCF_RD_NONE, 32'hFFFFFFFF, q);
        pin(1'b1, 1'b0);
        seed = lfsr(seed);
        wr(PCF_OFS_PERIOD, seed);
        wr(4'h6, 32'hFFFFFFFF);
        rd(PCF_OFS_PERIOD, seed & 32'h0000FFFF, 32'hFFFFFFFF, q);
        bus(1'b1, PCF_OFS_DUTY, 32'h0000ABCD, 4'h1, q);
        rd(PCF_OFS_DUTY, 32'h000000CD, 32'hFFFFFFFF, q);
        wr(PCF_OFS_CTRL, 32'hFFFFFFFE);
        rd(PCF_OFS_CTRL, 32'h00001FFE, 32'hFFFFFFFF, q);
        for (k = 0; k < 4; k++) begin
            if (k == 2) continue;
            wr(PCF_OFS_CTRL, 32'h1 | (32'(k) << PCF_B_MODE) | (32'(k & 1) << PCF_B_SL));
            repeat (3) @(posedge core_clk);
            pin(~k[0], k[0]);
        end
        wr(PCF_OFS_PERIOD, 32'h0000000A);
        wr(PCF_OFS_DUTY, 32'h00000004);
        for (k = 0; k < 2; k++) begin
            cw(HI, LO, k[0], PCF_UD_UP, LO, LO, 2'h0, 2'h0, LO);
            repeat (30) @(posedge core_clk);
            h = 0;
            repeat (20) @(posedge core_clk) h += int'(main_waveform_output === 1'b1);
            ok(h == (k == 1 ? 8 : 12));
            rd(PCF_OFS_STATUS, 32'h0, 32'h1 << PCF_B_ST_DOWN, q);
        end
        wr(PCF_OFS_PERIOD, 32'h00000014);
        wr(PCF_OFS_DUTY, 32'h00000007);
        for (k = 0; k < 2; k++) begin
            cw(HI, LO, HI, 2'(k), HI, LO, 2'h0, 2'h0, LO);
            repeat (40) @(posedge core_clk);
            cw(LO, HI, HI, 2'(k), HI, LO, 2'h0, 2'h0, LO);
            repeat (3) @(posedge core_clk);
            m = main_waveform_output;
            c = complementary_waveform_output;
            r = rises;
            repeat (30) begin
                seed = lfsr(seed);
                pre_trig <= seed[0];
                cap_trig <= seed[1];
                @(posedge core_clk);
                pin(m, c);
            end
            check({16'h0, rises}, {16'h0, r});
        end
        pre_trig <= 1'b0;
        cap_trig <= 1'b0;
        wr(PCF_OFS_PERIOD, 32'h000000C8);
        wr(PCF_OFS_DUTY, 32'h0000FFFF);
        for (k = 0; k < 2; k++) begin
            cw(HI, LO, HI, 2'h1, HI, k[0], 2'h0, 2'h0, LO);
            repeat (3) @(posedge core_clk);
            pin(1'b1, 1'b0);
            cw(HI, LO, LO, 2'h1, HI, k[0], 2'h0, 2'h0, LO);
            repeat (2) @(posedge core_clk);
            pin(1'b0, 1'b1);
            h = 0;
            do begin
                rd(PCF_OFS_STATUS, 32'h0, 32'h0, q);
                h++;
            end while (!(q[PCF_B_ST_DOWN] === 1'b1 && q[15:0] < 150 && q[15:0] > 60) && h < 300);
            pulse(~k[0]);
            rd(PCF_OFS_STATUS, 32'h1 << PCF_B_ST_DOWN, 32'h1 << PCF_B_ST_DOWN, q);
            pulse(k[0]);
            rd(PCF_OFS_STATUS, 32'h0, 32'h1 << PCF_B_ST_DOWN, q);
        end
        wr(PCF_OFS_PERIOD, 32'h000003E8);
        wr(PCF_OFS_DUTY, 32'h00000005);
        for (k = 0; k < 4; k++) begin
            cw(HI, LO, HI, PCF_UD_UP, LO, LO, fu_tab[k], rc_tab[k], LO);
            repeat (150) @(posedge core_clk);
            cw(HI, LO, HI, PCF_UD_UP, LO, LO, fu_tab[k], rc_tab[k], HI);
            rd(PCF_OFS_STATUS, 32'h0, 32'h0, q);
            check({31'h0, q[15:0] < 20}, {31'h0, k == 0});
        end
        cw(HI, LO, HI, PCF_UD_UP, LO, LO, PCF_FUPD_ON, PCF_RSTCN_ON, HI);
        repeat (150) @(posedge core_clk);
        pin(1'b0, 1'b1);
        cw(HI, LO, HI, PCF_UD_UP, LO, LO, PCF_FUPD_ON, PCF_RSTCN_ON, HI);
        h = 0;
        while (main_waveform_output !== 1'b1 && h < 6) @(posedge core_clk) h++;
        pin(1'b1, 1'b0);
        h = 0;
        while (main_waveform_output === 1'b1 && h < 20) @(posedge core_clk) h++;
        ok(h >= 5 && h <= 6);
        // A duty of one lets the level-change check see its edge two cycles on
        wr(PCF_OFS_DUTY, 32'h00000001);
        repeat (150) @(posedge core_clk);
        cw(HI, LO, LO, PCF_UD_UP, LO, LO, PCF_FUPD_ON, PCF_RSTCN_ON, HI);
        h = 0;
        while (main_waveform_output !== 1'b1 && h < 30) @(posedge core_clk) h++;
        ok(h >= 3 && h <= 9);
        pin(1'b1, 1'b0);
        check({16'h0, clashes}, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
